// ---- src/tsscp_pkg.sv ----
package tsscp_pkg;

  // ---------------------------------------------------------------
  // Bus addresses of the two part variants
  // ---------------------------------------------------------------
  localparam logic [6:0] TSSCP_ADDR_VAR1 = 7'h28;
  localparam logic [6:0] TSSCP_ADDR_VAR2 = 7'h29;

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam int         TSSCP_BYTE_BITS = 8;
  localparam logic [3:0] TSSCP_CNT_FULL  = 4'h8;
  localparam logic [3:0] TSSCP_CNT_ZERO  = 4'h0;
  localparam logic [3:0] TSSCP_CNT_ONE   = 4'h1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TSSCP_CLK_HZ      = 25_000_000;
  localparam int TSSCP_TIMEOUT_MS  = 30;
  localparam int TSSCP_TIMEOUT_CYC = TSSCP_TIMEOUT_MS * (TSSCP_CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_RX     = 3'b011,
    ST_TX     = 3'b100,
    ST_HACK   = 3'b101,
    ST_IGNORE = 3'b110
  } tsscp_state_t;

endpackage

// ---- src/tsscp_line_if.sv ----
interface tsscp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport sync (output scl, sda, scl_rise, scl_fall, start, stop);
  modport core (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// ---- src/tsscp_line_sync.sv ----
module tsscp_line_sync
  import tsscp_pkg::*;
(
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   sys_rst,
  // Raw bus lines
  input  wire logic   scl_pin,
  input  wire logic   sda_pin,
  // Conditioned lines and events
  tsscp_line_if.sync  ln
);

  // ---------------------------------------------------------------
  // Two-stage synchronisers, third stage for edge finding
  // ---------------------------------------------------------------
  // Stage one feeds stage two only; edges compare stages two and three
  logic [2:0] scl_q, scl_d;
  logic [2:0] sda_q, sda_d;

  always_comb begin
    scl_d = {scl_q[1:0], scl_pin};
    sda_d = {sda_q[1:0], sda_pin};
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  assign ln.scl      = scl_q[1];
  assign ln.sda      = sda_q[1];
  assign ln.scl_rise = scl_q[1] & ~scl_q[2];
  assign ln.scl_fall = ~scl_q[1] & scl_q[2];
  // Both lines pass the same delay, so data stays aligned to the clock
  assign ln.start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign ln.stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

endmodule

// ---- src/tsscp_client.sv ----
module tsscp_client
  import tsscp_pkg::*;
#(
  parameter int VARIANT        = 0,
  parameter int TIMEOUT_CYCLES = TSSCP_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Serial bus pins
  input  wire logic       serial_clock_pin,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Configuration
  input  wire logic       timeout_en,
  // Received data
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  // Transmit data
  input  wire logic [7:0] tx_byte,
  output logic            tx_next,
  // Status
  output logic            addressed,
  output logic            host_read
);

  localparam int         TW      = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [6:0] OWN_ADR = (VARIANT == 1) ? TSSCP_ADDR_VAR2 : TSSCP_ADDR_VAR1;
  localparam logic [TW-1:0] TO_LIM = TW'(TIMEOUT_CYCLES);

  // Refuse parameter values at elaboration, before any logic is built
  if (VARIANT < 0 || VARIANT > 1) begin : g_bad_variant
    $error("VARIANT must be 0 or 1");
  end
  if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES must be at least 1");
  end

  // ---------------------------------------------------------------
  // Line conditioning
  // ---------------------------------------------------------------
  tsscp_line_if ln ();

  tsscp_line_sync u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .scl_pin (serial_clock_pin),
    .sda_pin (sda_in),
    .ln      (ln)
  );

  // ---------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------
  tsscp_state_t  st_q, st_d;
  logic [3:0]    cnt_q, cnt_d;
  logic [7:0]    sr_q, sr_d;
  logic [7:0]    rxb_q, rxb_d;
  logic          dir_q, dir_d;
  logic          oe_q, oe_d;
  logic          rxv_q, rxv_d;
  logic          txn_q, txn_d;
  logic          hack_q, hack_d;
  logic          adr_q, adr_d;
  logic [TW-1:0] to_q, to_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sr_d   = sr_q;
    rxb_d  = rxb_q;
    dir_d  = dir_q;
    oe_d   = oe_q;
    rxv_d  = 1'b0;
    txn_d  = 1'b0;
    hack_d = hack_q;
    // Counts only while the clock is held low inside a transaction
    if (timeout_en && !ln.scl && st_q != ST_IDLE && to_q != TO_LIM)
      to_d = to_q + TW'(1);
    else
      to_d = '0;
    if (ln.start) begin
      st_d  = ST_ADDR;
      cnt_d = TSSCP_CNT_ZERO;
      oe_d  = 1'b0;
    end else if (ln.stop || to_q == TO_LIM) begin
      st_d  = ST_IDLE;
      cnt_d = TSSCP_CNT_ZERO;
      oe_d  = 1'b0;
    end else begin
      // Only clock edges move the sequence here; a stretched low phase is harmless unless it reaches the enabled timeout
      case (st_q)
        ST_ADDR, ST_RX: begin
          if (ln.scl_rise && cnt_q != TSSCP_CNT_FULL) begin
            sr_d  = {sr_q[6:0], ln.sda};
            cnt_d = cnt_q + TSSCP_CNT_ONE;
          end else if (ln.scl_fall && cnt_q == TSSCP_CNT_FULL) begin
            if (st_q == ST_ADDR) begin
              if (sr_q[7:1] == OWN_ADR) begin
                dir_d = sr_q[0];
                oe_d  = 1'b1;
                st_d  = ST_ACK;
              end else begin
                st_d  = ST_IGNORE;
              end
            end else begin
              rxb_d = sr_q;
              rxv_d = 1'b1;
              oe_d  = 1'b1;
              st_d  = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (ln.scl_fall) begin
            if (dir_q) begin
              sr_d  = tx_byte;
              oe_d  = ~tx_byte[7];
              cnt_d = TSSCP_CNT_ONE;
              txn_d = 1'b1;
              st_d  = ST_TX;
            end else begin
              oe_d  = 1'b0;
              cnt_d = TSSCP_CNT_ZERO;
              st_d  = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (ln.scl_fall) begin
            if (cnt_q != TSSCP_CNT_FULL) begin
              sr_d  = {sr_q[6:0], 1'b0};
              oe_d  = ~sr_q[6];
              cnt_d = cnt_q + TSSCP_CNT_ONE;
            end else begin
              oe_d  = 1'b0;
              st_d  = ST_HACK;
            end
          end
        end
        ST_HACK: begin
          if (ln.scl_rise)
            hack_d = ~ln.sda;
          else if (ln.scl_fall) begin
            if (hack_q) begin
              sr_d  = tx_byte;
              oe_d  = ~tx_byte[7];
              cnt_d = TSSCP_CNT_ONE;
              txn_d = 1'b1;
              st_d  = ST_TX;
            end else begin
              // A refused byte ends the read; wait for stop or start
              st_d  = ST_IGNORE;
            end
          end
        end
        ST_IGNORE: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
    adr_d = (st_d == ST_ACK) || (st_d == ST_RX) || (st_d == ST_TX) || (st_d == ST_HACK);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q   <= ST_IDLE;
      cnt_q  <= TSSCP_CNT_ZERO;
      sr_q   <= 8'h00;
      rxb_q  <= 8'h00;
      dir_q  <= 1'b0;
      oe_q   <= 1'b0;
      rxv_q  <= 1'b0;
      txn_q  <= 1'b0;
      hack_q <= 1'b0;
      adr_q  <= 1'b0;
      to_q   <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sr_q   <= sr_d;
      rxb_q  <= rxb_d;
      dir_q  <= dir_d;
      oe_q   <= oe_d;
      rxv_q  <= rxv_d;
      txn_q  <= txn_d;
      hack_q <= hack_d;
      adr_q  <= adr_d;
      to_q   <= to_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open-drain: the driven level is always low, only the enable moves.
  // No clock output exists at all, so the clock is never stretched.
  assign sda_out   = 1'b0;
  assign sda_oe    = oe_q;
  assign rx_byte   = rxb_q;
  assign rx_valid  = rxv_q;
  assign tx_next   = txn_q;
  assign addressed = adr_q;
  assign host_read = dir_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_oe_quiet_high;
    ln.scl && $past(ln.scl) && !ln.start && !ln.stop |-> $stable(oe_q) || st_q == ST_IDLE;
  endproperty
  a_oe_quiet_high: assert property (p_oe_quiet_high)
    else $error("data enable moved while clock high");

  property p_hold_low;
    st_q != ST_IDLE && !ln.scl_rise && !ln.scl_fall && !ln.start && !ln.stop
      && to_q != TO_LIM |=> $stable(st_q) && $stable(cnt_q);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("state moved without a clock edge");

  property p_start;
    ln.start |=> st_q == ST_ADDR && cnt_q == TSSCP_CNT_ZERO && !oe_q;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");

  property p_match;
    st_q == ST_ADDR && ln.scl_fall && cnt_q == TSSCP_CNT_FULL && sr_q[7:1] == OWN_ADR
      && !ln.start && !ln.stop && to_q != TO_LIM |=> st_q == ST_ACK && oe_q && dir_q == $past(sr_q[0]);
  endproperty
  a_match: assert property (p_match)
    else $error("own address not acknowledged");

  property p_mismatch;
    st_q == ST_ADDR && ln.scl_fall && cnt_q == TSSCP_CNT_FULL && sr_q[7:1] != OWN_ADR
      && !ln.start && !ln.stop && to_q != TO_LIM |=> st_q == ST_IGNORE && !oe_q;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("foreign address not ignored");

  property p_rx_ack;
    rxv_q |-> oe_q && st_q == ST_ACK;
  endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("received byte not acknowledged");

  property p_read_go;
    st_q == ST_ACK && dir_q && ln.scl_fall && !ln.start && !ln.stop && to_q != TO_LIM
      |=> txn_q && st_q == ST_TX && oe_q == ~$past(tx_byte[7]);
  endproperty
  a_read_go: assert property (p_read_go)
    else $error("read did not start with msb");

  property p_stop;
    ln.stop && !ln.start |=> st_q == ST_IDLE && !oe_q ##1 !adr_q;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop not honoured");

  property p_timeout;
    to_q == TO_LIM && !ln.start |=> st_q == ST_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not reset");

  property p_cnt_range;
    cnt_q <= TSSCP_CNT_FULL;
  endproperty
  a_cnt_range: assert property (p_cnt_range)
    else $error("bit count beyond a byte");

  c_write: cover property (rxv_q);
  c_read:  cover property (txn_q ##[1:1000] st_q == ST_HACK);
  c_other: cover property (st_q == ST_IGNORE);
  c_tmo:   cover property (to_q == TO_LIM);

endmodule

// ---- tb/tsscp_host_model.sv ----
module tsscp_host_model (
  // Clock
  input  wire logic mclk,
  // Bus wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Extra low time per bit, to stretch the clock
  int stretch = 0;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Data falls while the clock is high; also a repeated start
  task automatic start();
    wt(2);
    sda_low = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    wt(2);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(8);
  endtask

  // Data only moves while the clock is low
  task automatic bit_x(input logic b, output logic s);
    wt(2);
    sda_low = ~b;
    wt(2 + stretch);
    scl = 1'b1;
    wt(2);
    s = sda_line;
    wt(2);
    scl = 1'b0;
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(~ack, s);
  endtask
endmodule

// ---- tb/tsscp_bench.sv ----
module tsscp_bench
  import tsscp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TO    = 200;
  localparam int LIMIT = 20000;

  logic       mclk;
  logic       sys_rst;
  logic       timeout_en;
  logic       serial_clock_pin;
  logic       host_low;
  logic       sda_line;
  logic       oe1;
  logic       oe2;
  logic       sda_out1;
  logic [7:0] rx_byte1;
  logic       rx_valid1;
  logic [7:0] tx_byte;
  logic       tx_next1;
  logic       tx_next2;
  logic       addressed1;
  logic       addressed2;
  logic       host_read1;
  logic [7:0] rx_cnt = 8'h00;
  logic [7:0] tx_cnt = 8'h00;
  logic [7:0] tx_base = 8'h00;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  // Open drain with pull-up: both clients share the wire
  assign sda_line = ~(host_low | oe1 | oe2);
  assign tx_byte  = 8'hC3 ^ {2{tx_cnt[3:0] - tx_base[3:0]}};

  tsscp_client #(.VARIANT(0), .TIMEOUT_CYCLES(TO)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .serial_clock_pin(serial_clock_pin),
    .sda_in(sda_line), .sda_out(sda_out1), .sda_oe(oe1), .timeout_en(timeout_en),
    .rx_byte(rx_byte1), .rx_valid(rx_valid1), .tx_byte(tx_byte),
    .tx_next(tx_next1), .addressed(addressed1), .host_read(host_read1));

  tsscp_client #(.VARIANT(1), .TIMEOUT_CYCLES(TO)) i_dut2 (
    .mclk(mclk), .sys_rst(sys_rst), .serial_clock_pin(serial_clock_pin),
    .sda_in(sda_line), .sda_out(), .sda_oe(oe2), .timeout_en(timeout_en),
    .rx_byte(), .rx_valid(), .tx_byte(tx_byte),
    .tx_next(tx_next2), .addressed(addressed2), .host_read());

  tsscp_host_model i_host (
    .mclk(mclk), .sda_line(sda_line), .scl(serial_clock_pin), .sda_low(host_low));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (rx_valid1 === 1'b1) rx_cnt <= rx_cnt + 8'h01;
    if ((tx_next1 | tx_next2) === 1'b1) tx_cnt <= tx_cnt + 8'h01;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic t_write();
    logic ack;
    logic [7:0] r0;
    r0 = rx_cnt;
    i_host.start();
    i_host.put({TSSCP_ADDR_VAR1, 1'b0}, ack);
    check("addr ack", ack, 1'b1);
    check("addressed", addressed1, 1'b1);
    check("other variant", addressed2, 1'b0);
    check("direction", host_read1, 1'b0);
    check("data drive level", sda_out1, 1'b0);
    i_host.put(8'hA5, ack);
    check("data ack", ack, 1'b1);
    check("rx byte", rx_byte1, 8'hA5);
    i_host.stretch = 40;
    i_host.put(8'h3C, ack);
    i_host.stretch = 0;
    check("stretched ack", ack, 1'b1);
    check("stretched byte", rx_byte1, 8'h3C);
    check("rx pulses", rx_cnt - r0, 8'h02);
    i_host.stop();
    check("idle after stop", addressed1, 1'b0);
    $display("test write done");
  endtask

  task automatic t_read();
    logic ack;
    logic [7:0] d;
    tx_base = tx_cnt;
    i_host.start();
    i_host.put({TSSCP_ADDR_VAR1, 1'b1}, ack);
    check("read addr ack", ack, 1'b1);
    check("read direction", host_read1, 1'b1);
    i_host.get(1'b1, d);
    check("read byte 0", d, 8'hC3);
    i_host.get(1'b0, d);
    check("read byte 1", d, 8'hD2);
    check("loads", tx_cnt - tx_base, 8'h02);
    i_host.stop();
    $display("test read done");
  endtask

  task automatic t_foreign();
    logic ack;
    logic [7:0] r0;
    r0 = rx_cnt;
    i_host.start();
    i_host.put(8'h54, ack);
    check("foreign nack", ack, 1'b0);
    i_host.put(8'h00, ack);
    check("ignored byte", ack, 1'b0);
    check("no rx", rx_cnt - r0, 8'h00);
    i_host.start();
    i_host.put({TSSCP_ADDR_VAR2, 1'b0}, ack);
    check("variant 2 ack", ack, 1'b1);
    check("variant 2 addressed", addressed2, 1'b1);
    check("variant 1 silent", addressed1, 1'b0);
    i_host.stop();
    $display("test foreign done");
  endtask

  task automatic t_timeout();
    logic ack;
    logic s;
    i_host.start();
    i_host.put({TSSCP_ADDR_VAR1, 1'b0}, ack);
    // Eight data bits, then the clock stays low while the client drives its ack
    for (int i = 0; i < 8; i++) i_host.bit_x(1'b1, s);
    i_host.wt(TO + 20);
    check("no timeout when off", addressed1, 1'b1);
    check("ack held in long low", oe1, 1'b1);
    timeout_en = 1'b1;
    i_host.wt(TO + 20);
    check("timed out", addressed1, 1'b0);
    check("released", oe1, 1'b0);
    i_host.put(8'h77, ack);
    check("ignored after timeout", ack, 1'b0);
    i_host.start();
    i_host.put({TSSCP_ADDR_VAR1, 1'b0}, ack);
    check("ack after restart", ack, 1'b1);
    i_host.stop();
    timeout_en = 1'b0;
    $display("test timeout done");
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    timeout_en = 1'b0;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_write();
    t_read();
    t_foreign();
    t_timeout();
    test_done();
  end
endmodule
